//--- hw/slpc_pin_config.sv
// Strap latching, indicator pins, general I/O and ready delay
`timescale 1ns/100ps

module slpc_pin_config
  import slpc_pkg::*;
(
  input wire logic clk_sys, // System clock 250 MHz
  input wire logic rst_n, // Synchronous reset
  input wire logic power_on_reset_n, // Power-on reset pin
  input wire logic test_mode_pin, // Test-mode pin
  input wire logic eeprom_serial_clock_in, // EEPROM clock pin level
  output logic eeprom_serial_clock_out, // EEPROM clock drive
  output logic eeprom_serial_clock_oe, // EEPROM clock enable
  input wire logic eeprom_select_in, // EEPROM select pin level
  output logic eeprom_select_out, // EEPROM select drive
  output logic eeprom_select_oe, // EEPROM select enable
  input wire logic eeprom_serial_data_in, // EEPROM data pin level
  output logic eeprom_serial_data_out, // EEPROM data drive
  output logic eeprom_serial_data_oe, // EEPROM data enable
  input wire logic wake_pin_in, // Wake pin level
  output logic wake_pin_out, // Wake pin drive
  output logic wake_pin_oe, // Wake pin enable
  input wire logic general_out_line_six_in, // Line six pin level
  output logic general_out_line_six_out, // Line six drive
  output logic general_out_line_six_oe, // Line six enable
  input wire logic [GP_IO_W-1:0] general_io_lines_in, // General I/O levels
  output logic [GP_IO_W-1:0] general_io_lines_out, // General I/O drive
  output logic [GP_IO_W-1:0] general_io_lines_oe, // General I/O enables
  output logic speed_indicator_out, // Speed pin drive
  output logic speed_indicator_oe, // Speed pin enable
  output logic link_activity_indicator_out, // Link pin drive
  output logic link_activity_indicator_oe, // Link pin enable
  output logic int_pin_out, // Interrupt pin drive
  output logic int_pin_oe, // Interrupt pin enable
  input wire logic fiber_signal_detect, // Fiber signal detect pin
  input wire logic phy_speed_100, // PHY at 100 Mb/s
  input wire logic phy_link, // PHY link up
  input wire logic phy_carrier, // PHY carrier sense
  input wire logic mdix_mode, // Crossed pair mode
  input wire logic fiber_mode, // Fiber mode selected
  input wire slpc_ee_cfg_t ee_cfg, // Settings from EEPROM
  input wire slpc_ee_drv_t ee_drv, // EEPROM serial engine drive
  input wire logic isa_io16, // IO16 request
  input wire logic isa_iowait, // IOWAIT request
  input wire logic wake_event, // Wake-up event
  input wire logic int_request, // Internal interrupt request
  input wire logic gp_ctrl_wr, // Write control register
  input wire logic [GP_IO_W-1:0] gp_ctrl_wdata, // Control data, 1 = output
  input wire logic gp_data_wr, // Write data register
  input wire logic [GP_IO_W:0] gp_data_wdata, // Top bit drives line six
  output logic [GP_IO_W-1:0] general_io_control_reg, // Direction register
  output logic [GP_IO_W:0] general_io_data_reg, // Data register
  output logic [GP_IO_W-1:0] gp_in_data, // Sampled general I/O levels
  output logic eeprom_data_in, // Sampled EEPROM data
  output slpc_strap_t strap, // Latched straps
  output logic device_ready, // Ready for host access
  output logic normal_mode, // Normal operating mode
  output logic fiber_rx_valid, // Optical receive valid
  output logic pair1_is_rx, // First pair receives
  output logic pair2_is_rx // Second pair receives
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SYNC_W = 7 + GP_IO_W;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic por_q;
  logic [GP_IO_W-1:0] io_s;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {power_on_reset_n, test_mode_pin, eeprom_serial_clock_in, eeprom_select_in,
                wake_pin_in, general_out_line_six_in, eeprom_serial_data_in,
                general_io_lines_in};
      sync2 <= sync1;
    end
  end

  logic por_s;
  logic test_s;
  logic ck_s;
  logic sel_s;
  logic wake_s;
  logic six_s;
  logic dat_s;
  assign {por_s, test_s, ck_s, sel_s, wake_s, six_s, dat_s, io_s} = sync2;

  logic detect_s1;
  logic detect_s2;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      detect_s1 <= 1'b0;
      detect_s2 <= 1'b0;
      por_q <= 1'b0;
    end else begin
      detect_s1 <= fiber_signal_detect;
      detect_s2 <= detect_s1;
      por_q <= por_s;
    end
  end

  logic por_release;
  assign por_release = por_s && !por_q;

  ////////////////////////////////////////////////////////////////////////////
  // Ready sequencing
  slpc_state_t state;
  logic [READY_CNT_W-1:0] ready_cnt;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_s) begin
      state <= ST_HOLD;
      ready_cnt <= READY_CNT_RST;
    end else begin
      case (state)
        ST_HOLD: begin
          if (por_release) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ready_cnt == READY_LAST) begin
            state <= ST_RUN;
          end else begin
            ready_cnt <= ready_cnt + 11'h001;
          end
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_HOLD;
      endcase
    end
  end

  logic run;
  assign run = (state == ST_RUN);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      device_ready <= 1'b0;
    end else begin
      device_ready <= run && por_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap latch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap <= STRAP_RST;
    end else if (por_release) begin
      // Pins undriven until ready, so only a pull-up reads one
      strap.int_active_low <= ck_s;
      strap.bus_8bit <= sel_s;
      strap.cs_active_high <= sel_s && wake_s;
      strap.int_open_drain <= sel_s && six_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General I/O registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_s) begin
      general_io_control_reg <= GP_CTRL_RST;
      general_io_data_reg <= {GP_OUT6_RST, GP_DATA_RST};
    end else begin
      if (gp_ctrl_wr) begin
        general_io_control_reg <= gp_ctrl_wdata;
      end
      if (gp_data_wr) begin
        general_io_data_reg <= gp_data_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      general_io_lines_oe <= '0;
      general_io_lines_out <= '0;
      gp_in_data <= '0;
    end else begin
      general_io_lines_oe <= run ? general_io_control_reg : '0;
      general_io_lines_out <= general_io_data_reg[GP_IO_W-1:0];
      gp_in_data <= io_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // EEPROM, wake, line six and interrupt pins
  logic int_level;
  assign int_level = int_request ^ strap.int_active_low;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eeprom_serial_clock_out <= 1'b0;
      eeprom_serial_clock_oe <= 1'b0;
      eeprom_select_out <= 1'b0;
      eeprom_select_oe <= 1'b0;
      eeprom_serial_data_out <= 1'b0;
      eeprom_serial_data_oe <= 1'b0;
      eeprom_data_in <= 1'b0;
      wake_pin_out <= 1'b0;
      wake_pin_oe <= 1'b0;
      general_out_line_six_out <= 1'b0;
      general_out_line_six_oe <= 1'b0;
      int_pin_out <= 1'b0;
      int_pin_oe <= 1'b0;
    end else begin
      eeprom_serial_clock_out <= ee_drv.clk;
      eeprom_serial_clock_oe <= run;
      eeprom_select_out <= ee_drv.sel;
      eeprom_select_oe <= run;
      eeprom_serial_data_out <= ee_drv.dout;
      eeprom_serial_data_oe <= run && ee_drv.doe;
      eeprom_data_in <= dat_s;
      wake_pin_out <= wake_event;
      wake_pin_oe <= run && strap.bus_8bit;
      general_out_line_six_out <= general_io_data_reg[GP_IO_W];
      general_out_line_six_oe <= run && strap.bus_8bit;
      if (strap.int_open_drain) begin
        int_pin_out <= 1'b0;
        int_pin_oe <= run && (int_level == 1'b0);
      end else begin
        int_pin_out <= int_level;
        int_pin_oe <= run;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators and alternate bus functions
  logic alt16;
  assign alt16 = !strap.bus_8bit;
  logic link_on;
  assign link_on = (ee_cfg.led_mode == LED_MODE_COMBINED) ? (phy_link || phy_carrier)
                                                           : phy_carrier;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      speed_indicator_out <= 1'b0;
      speed_indicator_oe <= 1'b0;
      link_activity_indicator_out <= 1'b0;
      link_activity_indicator_oe <= 1'b0;
    end else begin
      if (alt16 && ee_cfg.io16_on_speed) begin
        speed_indicator_out <= isa_io16;
        speed_indicator_oe <= run;
      end else begin
        speed_indicator_out <= LED_ON_LEVEL;
        speed_indicator_oe <= run && phy_speed_100;
      end
      if (alt16 && ee_cfg.alt_on_link) begin
        link_activity_indicator_out <= ee_cfg.alt_is_wake ? wake_event : isa_iowait;
        link_activity_indicator_oe <= run;
      end else begin
        link_activity_indicator_out <= LED_ON_LEVEL;
        link_activity_indicator_oe <= run && link_on;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair roles, test mode, fiber
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pair1_is_rx <= 1'b1;
      pair2_is_rx <= 1'b0;
      normal_mode <= 1'b0;
      fiber_rx_valid <= 1'b0;
    end else begin
      pair1_is_rx <= !mdix_mode;
      pair2_is_rx <= mdix_mode;
      normal_mode <= run && !test_s;
      fiber_rx_valid <= fiber_mode && detect_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence release_seen;
    por_release;
  endsequence
  sequence wait_done;
    state == ST_WAIT && ready_cnt == READY_LAST && por_s;
  endsequence
  ready_delay_a: assert property (wait_done ##1 por_s |=> device_ready)
    else $error("ready not raised after wait");
  ready_early_a: assert property (release_seen |=> !device_ready [*8])
    else $error("ready raised too early");
  strap_hold_a: assert property (!por_release && !$past(por_release) |=> $stable(strap))
    else $error("strap changed without release");
  strap_int_a: assert property (release_seen |=> strap.int_active_low == $past(ck_s))
    else $error("interrupt polarity strap wrong");
  strap_bus_a: assert property (release_seen |=> strap.bus_8bit == $past(sel_s))
    else $error("bus width strap wrong");
  strap_cs_a: assert property (
    release_seen |=> strap.cs_active_high == ($past(sel_s) && $past(wake_s)))
    else $error("chip select strap wrong");
  strap_od_a: assert property (
    release_seen |=> strap.int_open_drain == ($past(sel_s) && $past(six_s)))
    else $error("open-drain strap wrong");
  gp_input_a: assert property (!run |=> general_io_lines_oe == '0)
    else $error("general I/O driven before ready");
  speed_led_a: assert property (run && strap.bus_8bit && !phy_speed_100
                                |=> !speed_indicator_oe)
    else $error("speed pin driven at 10 Mb/s");
  link_led_a: assert property (run && strap.bus_8bit && ee_cfg.led_mode == LED_MODE_CARRIER
                               |=> link_activity_indicator_oe == $past(phy_carrier))
    else $error("link pin not following carrier");
  pair_role_a: assert property (
    ##1 pair2_is_rx == $past(mdix_mode) && pair1_is_rx != pair2_is_rx)
    else $error("pair roles not following mode");
  normal_test_a: assert property (test_s |=> !normal_mode)
    else $error("normal mode with test input high");
endmodule

//--- hw/slpc_pkg.sv
// Constants and carrier types for strap latching and pin configuration
package slpc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int READY_TIME_NS = 5000;
  localparam int READY_CYCLES = (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_CNT_W = 11;
  localparam logic [READY_CNT_W-1:0] READY_LAST = READY_CNT_W'(READY_CYCLES - 1);
  localparam logic [READY_CNT_W-1:0] READY_CNT_RST = 11'h000;
  localparam int GP_IO_W = 3;
  localparam logic [GP_IO_W-1:0] GP_CTRL_RST = 3'h0;
  localparam logic [GP_IO_W-1:0] GP_DATA_RST = 3'h0;
  localparam logic GP_OUT6_RST = 1'h0;
  localparam logic LED_MODE_CARRIER = 1'h0;
  localparam logic LED_MODE_COMBINED = 1'h1;
  localparam logic LED_ON_LEVEL = 1'h0;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } slpc_state_t;

  typedef struct packed {
    logic int_active_low;
    logic bus_8bit;
    logic cs_active_high;
    logic int_open_drain;
  } slpc_strap_t;

  localparam slpc_strap_t STRAP_RST = 4'h0;

  typedef struct packed {
    logic led_mode;
    logic io16_on_speed;
    logic alt_on_link;
    logic alt_is_wake;
  } slpc_ee_cfg_t;

  typedef struct packed {
    logic clk;
    logic sel;
    logic dout;
    logic doe;
  } slpc_ee_drv_t;
endpackage

//--- verif/slpc_board_model.sv
// Board model: strap resistors and serial EEPROM data answer
`timescale 1ns/100ps
module slpc_board_model
  import slpc_pkg::*;
(
  input wire logic [3:0] pull_up, // Straps: clock, select, wake, six
  input wire logic ee_bit, // EEPROM answer bit
  input wire logic [GP_IO_W-1:0] gp_pull, // General I/O board levels
  input wire logic [4:0] d_out, // Drive: clock, select, data, wake, six
  input wire logic [4:0] d_oe, // Enables, same order
  input wire logic [GP_IO_W-1:0] gp_out, // General I/O drive
  input wire logic [GP_IO_W-1:0] gp_oe, // General I/O enables
  output logic [4:0] pin, // Resolved levels
  output logic [GP_IO_W-1:0] gp_pin // Resolved general I/O levels
);
  logic [4:0] idle;
  always_comb begin
    idle = {pull_up[3:2], 1'h0, pull_up[1:0]};
    if (d_out[3] && d_oe[3] && !d_oe[2]) begin
      idle[2] = ee_bit;
    end
  end
  assign pin = (d_oe & d_out) | (~d_oe & idle);
  assign gp_pin = (gp_oe & gp_out) | (~gp_oe & gp_pull);
endmodule

//--- verif/test_slpc_pin_config.sv
// Testbench for strap latching and pin configuration
`timescale 1ns/100ps
module test_slpc_pin_config;
  import slpc_pkg::*;
  logic clk_sys, rst_n, por_n, test_pin, sig_det, spd, lnk, car, mdix, fib, io16, iowait, wake;
  logic irq, ctrl_wr, data_wr, ee_bit, spd_o, spd_oe, lnk_o, lnk_oe, int_o, int_oe;
  logic ee_in, ready, normal, fib_v, p1, p2;
  logic [2:0] ctrl_wd, gp_pull, gp_ctrl, gp_in;
  logic [3:0] data_wd, pull_up, gp_data;
  slpc_ee_cfg_t cfg;
  slpc_ee_drv_t drv;
  slpc_strap_t strap;
  wire [4:0] d_out, d_oe, pin;
  wire [2:0] gp_out, gp_oe, gp_pin;
  int n_mismatch = 0;
  int checks_done = 0;

  slpc_pin_config i_slpc_pin_config (
    .clk_sys(clk_sys), .rst_n(rst_n), .power_on_reset_n(por_n), .test_mode_pin(test_pin),
    .eeprom_serial_clock_in(pin[4]), .eeprom_serial_clock_out(d_out[4]),
    .eeprom_serial_clock_oe(d_oe[4]), .eeprom_select_in(pin[3]),
    .eeprom_select_out(d_out[3]), .eeprom_select_oe(d_oe[3]),
    .eeprom_serial_data_in(pin[2]), .eeprom_serial_data_out(d_out[2]),
    .eeprom_serial_data_oe(d_oe[2]), .wake_pin_in(pin[1]), .wake_pin_out(d_out[1]),
    .wake_pin_oe(d_oe[1]), .general_out_line_six_in(pin[0]),
    .general_out_line_six_out(d_out[0]), .general_out_line_six_oe(d_oe[0]),
    .general_io_lines_in(gp_pin), .general_io_lines_out(gp_out), .general_io_lines_oe(gp_oe),
    .speed_indicator_out(spd_o), .speed_indicator_oe(spd_oe),
    .link_activity_indicator_out(lnk_o), .link_activity_indicator_oe(lnk_oe),
    .int_pin_out(int_o), .int_pin_oe(int_oe), .fiber_signal_detect(sig_det),
    .phy_speed_100(spd), .phy_link(lnk), .phy_carrier(car), .mdix_mode(mdix),
    .fiber_mode(fib), .ee_cfg(cfg), .ee_drv(drv), .isa_io16(io16), .isa_iowait(iowait),
    .wake_event(wake), .int_request(irq), .gp_ctrl_wr(ctrl_wr), .gp_ctrl_wdata(ctrl_wd),
    .gp_data_wr(data_wr), .gp_data_wdata(data_wd), .general_io_control_reg(gp_ctrl),
    .general_io_data_reg(gp_data), .gp_in_data(gp_in), .eeprom_data_in(ee_in),
    .strap(strap), .device_ready(ready), .normal_mode(normal), .fiber_rx_valid(fib_v),
    .pair1_is_rx(p1), .pair2_is_rx(p2)
  );

  slpc_board_model i_slpc_board_model (
    .pull_up(pull_up), .ee_bit(ee_bit), .gp_pull(gp_pull), .d_out(d_out), .d_oe(d_oe),
    .gp_out(gp_out), .gp_oe(gp_oe), .pin(pin), .gp_pin(gp_pin)
  );

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Strap set {clock, select, wake, six}, power-on, ready wait, interrupt pin
  task automatic power_on(input logic [3:0] s);
    int n;
    logic od;
    n = 0;
    od = s[2] & s[0];
    pull_up = s;
    por_n = 1'h0;
    cyc(5);
    por_n = 1'h1;
    while (ready !== 1'h1 && n < 2000) begin
      cyc(1);
      n++;
      if (n == 100) chk({5'h0, gp_oe}, 8'h00);
    end
    chk(8'(n >= READY_CYCLES && n < READY_CYCLES + 10), 8'h01);
    chk({4'h0, strap}, {4'h0, s[3], s[2], s[2] & s[1], od});
    pull_up = ~s;
    cyc(8);
    chk({4'h0, strap}, {4'h0, s[3], s[2], s[2] & s[1], od});
    for (int k = 0; k < 2; k++) begin
      irq = k[0];
      cyc(4);
      chk({6'h0, int_o, int_oe}, od ? {7'h0, ~(k[0] ^ s[3])} : {6'h0, k[0] ^ s[3], 1'h1});
    end
    irq = 1'h0;
    $display("power-on test done, straps %h", s);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, por_n, test_pin, sig_det, spd, lnk, car, mdix, fib, io16, iowait, wake} = '0;
    {irq, ctrl_wr, data_wr, ee_bit, ctrl_wd, gp_pull, data_wd, pull_up, cfg, drv} = '0;
    cyc(10);
    chk({ready, p1, p2, gp_oe, int_oe, spd_oe}, 8'h40);
    rst_n = 1'h1;
    power_on(4'h8);
    cfg = 4'h6;
    io16 = 1'h1;
    iowait = 1'h1;
    cyc(4);
    chk({2'h0, d_oe[1:0], spd_o, spd_oe, lnk_o, lnk_oe}, 8'h0f);
    {io16, iowait, wake} = 3'h1;
    cfg = 4'h7;
    cyc(4);
    chk({4'h0, spd_o, spd_oe, lnk_o, lnk_oe}, 8'h07);
    {wake, cfg} = '0;
    $display("alternate pin test done");
    power_on(4'h7);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 8; k++) begin
        cfg.led_mode = m[0];
        {spd, lnk, car} = k[2:0];
        cyc(4);
        chk({4'h0, spd_o, spd_oe, lnk_o, lnk_oe}, {5'h0, k[2], 1'h0, k[0] | (m[0] & k[1])});
      end
    end
    wake = 1'h1;
    cyc(4);
    chk({6'h0, d_out[1], d_oe[1]}, 8'h03);
    wake = 1'h0;
    $display("indicator test done");
    gp_pull = 3'h6;
    {ctrl_wr, ctrl_wd, data_wr, data_wd} = {1'h1, 3'h5, 1'h1, 4'ha};
    cyc(1);
    {ctrl_wr, data_wr} = 2'h0;
    cyc(3);
    chk({gp_data, 1'h0, gp_ctrl}, 8'ha5);
    cyc(3);
    chk({d_oe[0], d_out[0], gp_oe, gp_in}, 8'hea);
    $display("general io test done");
    for (int k = 0; k < 4; k++) begin
      {mdix, test_pin} = k[1:0];
      fib = 1'h1;
      sig_det = k[0];
      cyc(6);
      chk({4'h0, p1, p2, normal, fib_v}, {4'h0, ~k[1], k[1], ~k[0], k[0]});
    end
    test_pin = 1'h0;
    $display("mode pin test done");
    drv = 4'he;
    ee_bit = 1'h1;
    cyc(6);
    chk({2'h0, d_out[4:3], d_oe[4:2], ee_in}, 8'h3d);
    drv = 4'h7;
    ee_bit = 1'h0;
    cyc(6);
    chk({1'h0, d_out[4:2], d_oe[4:2], ee_in}, 8'h3f);
    drv = 4'h0;
    $display("eeprom pin test done");
    power_on(4'h4);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
endmodule
